// *** hw/swm_line_master.sv ***
// Configuration, read pointer and pullup control of the serial-bus to single-wire master.
// Assumes a line sequencer on the same clock runs the slot waveforms and reports status.
// The single-wire pin and the address straps are asynchronous and are synchronised here.

// Overview of operation
// - Three readable registers, only config is writable.
// - Last executed instruction sets the read pointer.
// - Reset leaves config at zero.
// - Config write needs upper nibble inverted lower.
// - Config upper nibble reads as zero.
// - Config bits: active, zero, strong, speed.
// - Options combine; strong select self-clears.
// - Active select off means resistor-only rising edges.
// - Active pullup drives from threshold for on-time.
// - No active pullup after presence or short.
// - Strong pullup drives transistor and external FET.
// - One time base for slots and on-time.
// - Line sequences run without host help.
// - Status and read data reported to host.
// - Two strap pins pick the slave address.
// - Host bus runs up to 400 kHz.
// - Strong pullup ends on command, clear, reset.
// - Speed select picks standard or overdrive timing.
// - Line commands and reset point at status.
module swm_line_master
  import swm_pkg::*;
#(
  parameter int APU_TICKS = APU_ON_TICKS
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Host serial bus
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_oe,
  // Address straps
  input wire logic i_slave_addr_pin_lo,
  input wire logic i_slave_addr_pin_hi,
  // Single-wire line
  input wire logic i_line,
  output logic o_pullup_drive,
  output logic o_ext_fet_ctrl_n,
  // Line sequencer
  output swm_cmd_t o_eng_cmd,
  output logic o_line_speed_select,
  output logic o_time_tick,
  input wire logic i_eng_busy,
  input wire logic [7:0] i_eng_status,
  input wire logic [7:0] i_eng_read_data,
  input wire logic i_eng_pulldown,
  input wire logic i_eng_passive_edge,
  input wire logic i_eng_spu_start
);

  localparam int TICK_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam int APU_W = (APU_TICKS > 1) ? $clog2(APU_TICKS) : 1;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam logic [APU_W-1:0] APU_LAST = APU_W'(APU_TICKS - 1);
  localparam int APU_MAX = APU_TICKS * TICK_CYCLES + 1;

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [1:0] addr_s1, addr_s2;
  logic line_s1, line_s2;
  swm_cfg_t cfg;
  logic rst_flag;
  swm_ptr_t ptr;
  logic [7:0] cmd_code;
  logic cmd_pending;
  logic [TICK_W-1:0] tick_cnt;
  logic [APU_W-1:0] apu_cnt;
  swm_pu_t pu_state;
  swm_pu_t next_pu;
  logic strong_arm;
  logic pd_d;
  swm_rx_t rx;
  swm_cfg_t wr_cfg;
  swm_ptr_t next_ptr;

  // ---------------------------------------------------------------------------
  // Host bus slave
  // ---------------------------------------------------------------------------
  wire [7:0] status_byte = (i_eng_status & ~STAT_RST_MASK) | (rst_flag ? STAT_RST_MASK : 8'h00);
  // The pointer stays put across reads, so repeated reads return one register.
  wire [7:0] tx_byte = (ptr == PTR_CONFIG) ? {CFG_UPPER_READ, cfg} :
                       (ptr == PTR_DATA) ? i_eng_read_data : status_byte;

  swm_i2c_slave u_slave (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_sda_oe(o_sda_oe),
    .i_addr_sel(addr_s2),
    .i_tx_byte(tx_byte),
    .o_rx(rx)
  );

  // ---------------------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------------------
  wire rx_cmd = rx.valid & rx.first;
  wire rx_par = rx.valid & ~rx.first & cmd_pending;
  wire [7:0] cmd_now = rx_cmd ? rx.data : cmd_code;
  wire [7:0] par = rx.data;
  wire exec = (rx_cmd & ~swm_needs_param(rx.data)) | rx_par;
  wire do_dev_reset = exec & (cmd_now == CMD_DEVICE_RESET);
  wire do_wr_cfg = exec & (cmd_now == CMD_WRITE_CONFIG);
  wire do_set_ptr = exec & (cmd_now == CMD_SET_POINTER);
  // A line command arriving while the sequencer is busy is dropped.
  wire do_line = exec & swm_is_line_cmd(cmd_now) & ~i_eng_busy;
  wire cfg_ok = par[7:4] == ~par[3:0];
  // A refused write is still acknowledged by the slave, but nothing here moves.
  wire cfg_take = do_wr_cfg & cfg_ok;
  // Bit 1 is forced to zero whatever the host wrote there.
  assign wr_cfg = '{line_speed_select: par[3], strong_pullup_select: par[2],
                    fixed_zero: 1'b0, active_pullup_select: par[0]};
  wire ptr_code_ok = (par == PTR_CODE_STATUS) | (par == PTR_CODE_DATA) | (par == PTR_CODE_CONFIG);
  wire swm_ptr_t par_ptr = (par == PTR_CODE_DATA) ? PTR_DATA :
                           (par == PTR_CODE_CONFIG) ? PTR_CONFIG : PTR_STATUS;
  // Whatever executed last decides what the next read returns.
  assign next_ptr = do_line ? PTR_STATUS :
                    cfg_take ? PTR_CONFIG :
                    (do_set_ptr & ptr_code_ok) ? par_ptr : ptr;

  // ---------------------------------------------------------------------------
  // Pullup control
  // ---------------------------------------------------------------------------
  wire tick = tick_cnt == TICK_LAST;
  wire apu_done = tick & (apu_cnt == APU_LAST);
  wire pd_fall = pd_d & ~i_eng_pulldown;
  wire spu_off_wr = cfg_take & ~wr_cfg.strong_pullup_select;
  wire strong_stop = (pu_state == PU_STRONG) & (next_pu != PU_STRONG);

  always_comb begin
    next_pu = pu_state;
    case (pu_state)
      PU_IDLE: begin
        if (i_eng_spu_start && cfg.strong_pullup_select) begin
          next_pu = PU_WAIT;
        end else if (pd_fall && cfg.active_pullup_select && !i_eng_passive_edge) begin
          next_pu = PU_WAIT;
        end
      end
      PU_WAIT: begin
        if (i_eng_pulldown || (i_eng_passive_edge && !strong_arm)) begin
          next_pu = PU_IDLE;
        end else if (line_s2) begin
          // The synchronised level flips inside the threshold band.
          next_pu = strong_arm ? PU_STRONG : PU_ACTIVE;
        end
      end
      PU_ACTIVE: begin
        if (i_eng_pulldown || apu_done) begin
          next_pu = PU_IDLE;
        end
      end
      PU_STRONG: begin
        if (do_line || spu_off_wr) begin
          next_pu = PU_IDLE;
        end
      end
      default: begin
        next_pu = PU_IDLE;
      end
    endcase
    if (do_dev_reset) begin
      next_pu = PU_IDLE;
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n || do_dev_reset) begin
      cfg <= CFG_RESET;
      rst_flag <= 1'b1;
      ptr <= PTR_STATUS;
    end else begin
      ptr <= next_ptr;
      if (cfg_take) begin
        cfg <= wr_cfg;
        rst_flag <= 1'b0;
      end
      if (strong_stop) begin
        cfg.strong_pullup_select <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      cmd_code <= 8'h00;
      cmd_pending <= 1'b0;
      o_eng_cmd <= '0;
    end else begin
      o_eng_cmd <= '{valid: do_line, code: cmd_now, data: par};
      if (rx_cmd) begin
        cmd_code <= rx.data;
        cmd_pending <= swm_needs_param(rx.data);
      end else if (rx_par) begin
        cmd_pending <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      addr_s1 <= 2'h0;
      addr_s2 <= 2'h0;
      line_s1 <= 1'b0;
      line_s2 <= 1'b0;
      pd_d <= 1'b0;
      tick_cnt <= '0;
      o_time_tick <= 1'b0;
      o_line_speed_select <= 1'b0;
    end else begin
      addr_s1 <= {i_slave_addr_pin_hi, i_slave_addr_pin_lo};
      addr_s2 <= addr_s1;
      line_s1 <= i_line;
      line_s2 <= line_s1;
      pd_d <= i_eng_pulldown;
      tick_cnt <= tick ? '0 : tick_cnt + TICK_W'(1);
      o_time_tick <= tick;
      o_line_speed_select <= cfg.line_speed_select;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      pu_state <= PU_IDLE;
      strong_arm <= 1'b0;
      apu_cnt <= '0;
      o_pullup_drive <= 1'b0;
      o_ext_fet_ctrl_n <= 1'b1;
    end else begin
      pu_state <= next_pu;
      if (pu_state == PU_IDLE) begin
        strong_arm <= i_eng_spu_start & cfg.strong_pullup_select;
      end
      if (pu_state != PU_ACTIVE) begin
        apu_cnt <= '0;
      end else if (tick) begin
        apu_cnt <= apu_cnt + APU_W'(1);
      end
      // Strong and active pullup share the one transistor.
      o_pullup_drive <= (next_pu == PU_ACTIVE) | (next_pu == PU_STRONG);
      o_ext_fet_ctrl_n <= next_pu != PU_STRONG;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  cfg_read_zero_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    ptr == PTR_CONFIG |-> tx_byte[7:4] == 4'h0 && tx_byte[1] == 1'b0)
    else $error("config read shows nonzero fixed bits");

  cfg_reject_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    do_wr_cfg && !cfg_ok |=> cfg == $past(cfg) && rst_flag == $past(rst_flag) &&
                             ptr == $past(ptr))
    else $error("rejected config write changed state");

  cfg_accept_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    cfg_take |=> cfg == $past(wr_cfg) && !rst_flag && ptr == PTR_CONFIG)
    else $error("accepted config write not stored");

  dev_reset_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    do_dev_reset |=> cfg == CFG_RESET && ptr == PTR_STATUS && rst_flag && o_ext_fet_ctrl_n)
    else $error("device reset left state behind");

  fet_strong_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    !o_ext_fet_ctrl_n |-> o_pullup_drive && pu_state == PU_STRONG)
    else $error("external FET low outside strong pullup");

  apu_off_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    pu_state == PU_IDLE && !cfg.active_pullup_select && !i_eng_spu_start |=> !o_pullup_drive)
    else $error("pullup drive with active pullup deselected");

  apu_len_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    $rose(o_pullup_drive) && o_ext_fet_ctrl_n |-> ##[1:APU_MAX] !o_pullup_drive)
    else $error("active pullup exceeded its on-time");

  passive_edge_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    i_eng_passive_edge && (pu_state == PU_IDLE || (pu_state == PU_WAIT && !strong_arm))
    |=> !o_pullup_drive)
    else $error("active pullup on a passive edge");

  spu_clear_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    pu_state == PU_STRONG ##1 pu_state != PU_STRONG |-> !cfg.strong_pullup_select)
    else $error("strong select not cleared after strong pullup");

  line_ptr_a: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    do_line |=> ptr == PTR_STATUS && o_eng_cmd.valid && o_eng_cmd.code == $past(cmd_now))
    else $error("line command did not launch or move pointer");

endmodule

// *** hw/swm_pkg.sv ***
// Shared constants, field layouts and carrier types for the single-wire master.
// Assumes a 40 MHz system clock and a synchronous active-low reset.
package swm_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  // One time base feeds the slot timing and the active pullup on-time.
  localparam int TIME_TICK_NS = 250;
  localparam int TICK_CYCLES = (TIME_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int APU_ON_TIME_NS = 2500;
  localparam int APU_ON_TICKS = APU_ON_TIME_NS / TIME_TICK_NS;

  // ---------------------------------------------------------------------------
  // Host bus addressing
  // ---------------------------------------------------------------------------
  // Fixed upper address bits; the value is arbitrary.
  localparam logic [4:0] I2C_ADDR_FIXED = 5'h0c;

  // ---------------------------------------------------------------------------
  // Register layout
  // ---------------------------------------------------------------------------
  localparam logic [3:0] CFG_RESET = 4'h0;
  localparam logic [3:0] CFG_UPPER_READ = 4'h0;
  localparam logic [7:0] STAT_RST_MASK = 8'h10;

  typedef struct packed {
    logic line_speed_select;
    logic strong_pullup_select;
    logic fixed_zero;
    logic active_pullup_select;
  } swm_cfg_t;

  typedef enum logic [1:0] {
    PTR_STATUS = 2'b00,
    PTR_DATA = 2'b01,
    PTR_CONFIG = 2'b10
  } swm_ptr_t;

  localparam logic [7:0] PTR_CODE_STATUS = 8'h00;
  localparam logic [7:0] PTR_CODE_DATA = 8'h01;
  localparam logic [7:0] PTR_CODE_CONFIG = 8'h02;

  // ---------------------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CMD_DEVICE_RESET = 8'h10;
  localparam logic [7:0] CMD_WRITE_CONFIG = 8'h20;
  localparam logic [7:0] CMD_SET_POINTER = 8'h30;
  localparam logic [7:0] CMD_LINE_RESET = 8'h40;
  localparam logic [7:0] CMD_WRITE_BYTE = 8'h50;
  localparam logic [7:0] CMD_READ_BYTE = 8'h60;
  localparam logic [7:0] CMD_SINGLE_BIT = 8'h70;
  localparam logic [7:0] CMD_TRIPLET = 8'h80;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic first;
    logic [7:0] data;
  } swm_rx_t;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [7:0] data;
  } swm_cmd_t;

  typedef enum logic [1:0] {
    PU_IDLE = 2'b00,
    PU_WAIT = 2'b01,
    PU_ACTIVE = 2'b10,
    PU_STRONG = 2'b11
  } swm_pu_t;

  function automatic logic swm_needs_param(input logic [7:0] code);
    swm_needs_param = (code == CMD_WRITE_CONFIG) || (code == CMD_SET_POINTER) ||
                      (code == CMD_WRITE_BYTE) || (code == CMD_SINGLE_BIT) ||
                      (code == CMD_TRIPLET);
  endfunction

  function automatic logic swm_is_line_cmd(input logic [7:0] code);
    swm_is_line_cmd = (code == CMD_LINE_RESET) || (code == CMD_WRITE_BYTE) ||
                      (code == CMD_READ_BYTE) || (code == CMD_SINGLE_BIT) ||
                      (code == CMD_TRIPLET);
  endfunction

endpackage

// *** hw/swm_i2c_slave.sv ***
// Byte-level serial host bus slave: start/stop detection, address match, ACK, read shifting.
// Assumes the bus pins are asynchronous and the address straps are already synchronised.
module swm_i2c_slave
  import swm_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_oe,
  // Register side
  input wire logic [1:0] i_addr_sel,
  input wire logic [7:0] i_tx_byte,
  output swm_rx_t o_rx
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_ACK_W = 3'b010,
    ST_ACK = 3'b011,
    ST_TX = 3'b100,
    ST_RACK_W = 3'b101,
    ST_RACK = 3'b110,
    ST_TX_NEXT = 3'b111
  } swm_i2c_st_t;

  swm_i2c_st_t st;
  logic scl_s1, scl_s2, scl_d;
  logic sda_s1, sda_s2, sda_d;
  logic [7:0] shift;
  logic [2:0] bit_cnt;
  logic addr_phase;
  logic first;
  logic rw;

  // ---------------------------------------------------------------------------
  // Edge and condition decode
  // ---------------------------------------------------------------------------
  // At 40 MHz a 400 kHz bus clock gives a hundred samples per bit.
  wire scl_rise = scl_s2 & ~scl_d;
  wire scl_fall = ~scl_s2 & scl_d;
  wire bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
  wire bus_stop = scl_s2 & scl_d & ~sda_d & sda_s2;
  wire [7:0] rx_byte = {shift[6:0], sda_s2};
  wire addr_hit = rx_byte[7:1] == {I2C_ADDR_FIXED, i_addr_sel};
  wire last_bit = bit_cnt == 3'h7;
  wire tx_load = scl_fall & (((st == ST_ACK) & addr_phase & rw) | (st == ST_TX_NEXT));

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      {scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d} <= 6'h3f;
      st <= ST_IDLE;
      shift <= 8'h00;
      bit_cnt <= 3'h0;
      addr_phase <= 1'b0;
      first <= 1'b0;
      rw <= 1'b0;
      o_sda_oe <= 1'b0;
      o_rx <= '0;
    end else begin
      scl_s1 <= i_scl;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= i_sda;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
      o_rx.valid <= 1'b0;
      if (bus_start) begin
        st <= ST_RX;
        bit_cnt <= 3'h0;
        addr_phase <= 1'b1;
        first <= 1'b1;
        o_sda_oe <= 1'b0;
      end else if (bus_stop) begin
        st <= ST_IDLE;
        o_sda_oe <= 1'b0;
      end else if (tx_load) begin
        shift <= i_tx_byte;
        o_sda_oe <= ~i_tx_byte[7];
        bit_cnt <= 3'h0;
        addr_phase <= 1'b0;
        st <= ST_TX;
      end else begin
        case (st)
          ST_RX: begin
            if (scl_rise) begin
              shift <= rx_byte;
              bit_cnt <= bit_cnt + 3'h1;
              if (last_bit && addr_phase) begin
                rw <= sda_s2;
                st <= addr_hit ? ST_ACK_W : ST_IDLE;
              end else if (last_bit) begin
                o_rx <= '{valid: 1'b1, first: first, data: rx_byte};
                first <= 1'b0;
                st <= ST_ACK_W;
              end
            end
          end
          ST_ACK_W: begin
            if (scl_fall) begin
              o_sda_oe <= 1'b1;
              st <= ST_ACK;
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              o_sda_oe <= 1'b0;
              addr_phase <= 1'b0;
              st <= ST_RX;
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 3'h1;
              if (last_bit) begin
                st <= ST_RACK_W;
              end
            end else if (scl_fall) begin
              o_sda_oe <= ~shift[6];
              shift <= {shift[6:0], 1'b0};
            end
          end
          ST_RACK_W: begin
            if (scl_fall) begin
              o_sda_oe <= 1'b0;
              st <= ST_RACK;
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              st <= sda_s2 ? ST_IDLE : ST_TX_NEXT;
            end
          end
          default: begin
            st <= st;
          end
        endcase
      end
    end
  end

endmodule

// *** verification/swm_host_model.sv ***
// Serial host bus master model with an open-drain data line and a pull-up.
// Assumes the device pulls data low while its output enable is high.
module swm_host_model (
  // Clock
  input wire logic i_mclk,
  // Bus pins
  input wire logic i_sda_oe,
  output logic o_scl,
  output logic o_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv_low = 1'b0;
  initial o_scl = 1'b1;
  // The pull-up wins unless some party pulls the line low.
  assign o_sda = !(drv_low || i_sda_oe);
  // ---------------------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------------------
  // A quarter bit of 25 clocks keeps the clock at 400 kHz.
  task automatic qtr();
    repeat (25) @(posedge i_mclk);
  endtask
  task automatic start();
    drv_low <= 1'b0;
    qtr();
    o_scl <= 1'b1;
    qtr();
    drv_low <= 1'b1;
    qtr();
    o_scl <= 1'b0;
    qtr();
  endtask
  task automatic stop();
    drv_low <= 1'b1;
    qtr();
    o_scl <= 1'b1;
    qtr();
    drv_low <= 1'b0;
    qtr();
  endtask
  task automatic bit_io(input logic b, output logic r);
    drv_low <= !b;
    qtr();
    o_scl <= 1'b1;
    qtr();
    r = o_sda;
    qtr();
    o_scl <= 1'b0;
    qtr();
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, ack);
  endtask
  task automatic rbyte(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, r);
  endtask
endmodule

// *** verification/test_swm_line_master.sv ***
// Self-checking bench for the configuration, pointer and pullup block.
// Assumes the host model drives the serial bus and the bench stands in for the sequencer.
`define CHK(n, e, g) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("ERROR %s exp %h got %h", n, e, g); \
  end \
end
module test_swm_line_master
  import swm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int APU_T = 2;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_line = 1'b1;
  logic busy = 1'b0, pd = 1'b0, pas = 1'b0, spu_go = 1'b0;
  logic [7:0] stat = 8'h0a;
  logic [7:0] rdat = 8'h5c;
  // The straps below tie the high pin low and the low pin high.
  localparam logic [6:0] DEV_ADDR = {I2C_ADDR_FIXED, 2'b01};
  logic scl, sda, sda_oe, pu, fet_n, spd, tick_o;
  swm_cmd_t cmd;
  logic [7:0] last_code = 8'h00;
  logic [7:0] last_data = 8'h00;
  int num_errors = 0;
  int n_checks = 0;
  always #12.5 i_mclk = ~i_mclk;
  always @(posedge i_mclk) if (cmd.valid) {last_code, last_data} <= {cmd.code, cmd.data};
  swm_host_model host (.i_mclk(i_mclk), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda));
  swm_line_master #(.APU_TICKS(APU_T)) uut (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda), .o_sda_oe(sda_oe),
    .i_slave_addr_pin_lo(1'b1), .i_slave_addr_pin_hi(1'b0), .i_line(i_line),
    .o_pullup_drive(pu), .o_ext_fet_ctrl_n(fet_n), .o_eng_cmd(cmd),
    .o_line_speed_select(spd), .o_time_tick(tick_o), .i_eng_busy(busy), .i_eng_status(stat),
    .i_eng_read_data(rdat), .i_eng_pulldown(pd), .i_eng_passive_edge(pas),
    .i_eng_spu_start(spu_go));
  // ---------------------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------------------
  task automatic op(input logic [7:0] c, input logic [7:0] p, input int n);
    logic ack;
    host.start();
    host.wbyte({DEV_ADDR, 1'b0}, ack);
    `CHK("addr ack", 1'b0, ack)
    host.wbyte(c, ack);
    if (n > 1) host.wbyte(p, ack);
    `CHK("data ack", 1'b0, ack)
    host.stop();
  endtask
  task automatic rd(input string nm, input logic [7:0] e);
    logic [7:0] d;
    logic ack;
    host.start();
    host.wbyte({DEV_ADDR, 1'b1}, ack);
    `CHK("read addr ack", 1'b0, ack)
    host.rbyte(d);
    host.stop();
    `CHK(nm, e, d)
  endtask
  // One pulldown slot, counting the cycles that the pullup transistor conducts.
  task automatic rise(input logic s, input logic p, output int hi);
    hi = 0;
    @(posedge i_mclk);
    pd <= 1'b1;
    i_line <= 1'b0;
    pas <= p;
    repeat (5) @(posedge i_mclk);
    pd <= 1'b0;
    spu_go <= s;
    @(posedge i_mclk);
    spu_go <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_line <= 1'b1;
    repeat (60) begin
      @(posedge i_mclk);
      hi += (pu === 1'b1);
    end
    pas <= 1'b0;
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------------
  initial begin
    int hi;
    int tk;
    tk = 0;
    repeat (6) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    // Count the time ticks over 4000 clocks before the first access.
    repeat (4000) begin
      @(posedge i_mclk);
      tk += (tick_o === 1'b1);
    end
    `CHK("tick rate", 1'b1, tk inside {[4000 / TICK_CYCLES - 1 : 4000 / TICK_CYCLES]})
    `CHK("fet idle", 1'b1, fet_n)
    rd("status rst", 8'h1a);
    op(CMD_SET_POINTER, PTR_CODE_DATA, 2);
    rd("data", 8'h5c);
    op(CMD_SET_POINTER, PTR_CODE_CONFIG, 2);
    rd("cfg rst", 8'h00);
    op(CMD_WRITE_CONFIG, 8'he1, 2);
    rd("cfg apu", 8'h01);
    op(CMD_WRITE_CONFIG, 8'h38, 2);
    rd("cfg rejected", 8'h01);
    op(CMD_SET_POINTER, PTR_CODE_STATUS, 2);
    rd("status clr", 8'h0a);
    op(CMD_WRITE_CONFIG, 8'h78, 2);
    rd("cfg speed", 8'h08);
    `CHK("speed out", 1'b1, spd)
    rise(1'b0, 1'b0, hi);
    `CHK("resistor only", 0, hi)
    op(CMD_WRITE_CONFIG, 8'h69, 2);
    rd("cfg combo", 8'h09);
    rise(1'b0, 1'b0, hi);
    `CHK("apu time", 1'b1, hi inside {[(APU_T - 1) * 10 : APU_T * 10 + 2]})
    rise(1'b0, 1'b1, hi);
    `CHK("passive edge", 0, hi)
    op(CMD_WRITE_CONFIG, 8'ha5, 2);
    rise(1'b1, 1'b0, hi);
    `CHK("strong drive", 1'b1, pu)
    `CHK("fet on", 1'b0, fet_n)
    op(CMD_READ_BYTE, 8'h00, 1);
    `CHK("launched", CMD_READ_BYTE, last_code)
    `CHK("strong end", 1'b0, pu)
    `CHK("fet off", 1'b1, fet_n)
    rd("ptr status", 8'h0a);
    op(CMD_SET_POINTER, PTR_CODE_CONFIG, 2);
    rd("spu cleared", 8'h01);
    // A line command while the sequencer is busy must neither launch nor move the pointer.
    busy <= 1'b1;
    op(CMD_LINE_RESET, 8'h00, 1);
    rd("busy ptr", 8'h01);
    `CHK("busy drop", CMD_READ_BYTE, last_code)
    busy <= 1'b0;
    op(CMD_WRITE_BYTE, 8'h3c, 2);
    `CHK("wbyte code", CMD_WRITE_BYTE, last_code)
    `CHK("wbyte data", 8'h3c, last_data)
    // Overdrive is selected as well, so that the reset below has a speed to clear.
    op(CMD_WRITE_CONFIG, 8'h2d, 2);
    rise(1'b1, 1'b0, hi);
    op(CMD_DEVICE_RESET, 8'h00, 1);
    `CHK("reset fet", 1'b1, fet_n)
    `CHK("reset speed", 1'b0, spd)
    rd("reset status", 8'h1a);
    op(CMD_SET_POINTER, PTR_CODE_CONFIG, 2);
    rd("reset cfg", 8'h00);
    end_sim();
  end
endmodule
